//--- rtl/bttm_pkg.sv
// Constants and types shared by the bit test-and-modify unit
package bttm_pkg;
  localparam int WORD_W = 24;
  // Wishbone register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_EA_ADDR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SR = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  // Command register field positions
  localparam int CMD_BIT_LSB = 0;
  localparam int CMD_BIT_W = 5;
  localparam int CMD_OP_POS = 5;
  localparam int CMD_SPACE_POS = 6;
  localparam int CMD_KIND_LSB = 7;
  localparam int CMD_FIELD_LSB = 10;
  localparam int FIELD_W = 6;
  // Status register bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_REJECT = 1;
  localparam int STAT_OLD_BIT = 2;
  // Status register (flags and mode byte) layout
  localparam int SR_CARRY = 0;
  localparam int SR_LIMIT = 6;
  localparam int SR_SCALE = 7;
  localparam int MODE_LSB = 8;
  localparam int MODE_MSB = 15;
  localparam logic [WORD_W-1:0] SR_RESET = 24'h000000;
  localparam logic [4:0] BIT_MAX = 5'h17;
  localparam logic [WORD_W-1:0] HIGH_IO_BASE = 24'hFFFFC0;
  localparam logic [WORD_W-1:0] LOW_IO_BASE = 24'hFFFF80;

  typedef enum logic [2:0] {
    KIND_EA = 3'b000,
    KIND_ABS = 3'b001,
    KIND_HIO = 3'b010,
    KIND_LIO = 3'b011,
    KIND_REG = 3'b100
  } bttm_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_REG = 2'b11
  } bttm_state_t;
endpackage

//--- rtl/bttm_unit.sv
// Bit test-and-invert / test-and-zero execution unit with Wishbone control
`timescale 1ns/10ps
module bttm_unit #(
  parameter logic [5:0] REG_SR_CODE = 6'h39,
  parameter logic [5:0] REG_ACC_A_CODE = 6'h0E,
  parameter logic [5:0] REG_ACC_B_CODE = 6'h0F
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_lock_o,
  output logic mem_space_o,
  output logic [bttm_pkg::WORD_W-1:0] mem_addr_o,
  output logic [bttm_pkg::WORD_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [bttm_pkg::WORD_W-1:0] mem_rdata_i,
  output logic [5:0] reg_sel_o,
  input wire logic [bttm_pkg::WORD_W-1:0] reg_rdata_i,
  output logic reg_we_o,
  output logic [bttm_pkg::WORD_W-1:0] reg_wdata_o,
  input wire logic std_limit_i,
  input wire logic std_scale_i
);
  import bttm_pkg::*;

  bttm_state_t state_q;
  bttm_kind_t kind_q;
  logic [4:0] bit_q;
  logic [5:0] field_q;
  logic op_zero_q, space_q, old_bit_q, reject_q, ack_q;
  logic mem_req_q, mem_we_q, mem_lock_q, reg_we_q;
  logic [31:0] dat_q;
  logic [WORD_W-1:0] ea_addr_q, sr_q, result_q, data_q;
  logic [WORD_W-1:0] mem_addr_q, mem_wdata_q, reg_wdata_q;
  logic wb_wr, cmd_wr, cmd_legal, start, sr_target, mem_done, reg_done;
  logic [4:0] cmd_bit;
  logic [2:0] cmd_kind;
  logic [5:0] cmd_field;
  logic [WORD_W-1:0] mask_w, src_word, new_word, dest_addr;

  // Bus slave answers every access one cycle after the strobe, mapped or not;
  // writes land on the ack edge, when the master is known to hold its data
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  assign cmd_bit = wb_dat_i[CMD_BIT_LSB +: CMD_BIT_W];
  assign cmd_kind = wb_dat_i[CMD_KIND_LSB +: 3];
  assign cmd_field = wb_dat_i[CMD_FIELD_LSB +: FIELD_W];
  assign cmd_wr = wb_wr && wb_adr_i == OFF_CMD && (&wb_sel_i[1:0]);

  always_comb begin
    cmd_legal = cmd_bit <= BIT_MAX;
    unique case (cmd_kind)
      KIND_EA, KIND_ABS, KIND_HIO, KIND_LIO: begin
      end
      KIND_REG: begin
        if (wb_dat_i[CMD_OP_POS] && (cmd_field == REG_ACC_A_CODE ||
            cmd_field == REG_ACC_B_CODE)) begin
          cmd_legal = 1'b0;
        end
      end
      default: cmd_legal = 1'b0;
    endcase
  end

  // Commands written while busy are dropped; software polls the busy bit
  assign start = cmd_wr && cmd_legal && state_q == ST_IDLE;

  assign mask_w = WORD_W'(1) << bit_q;
  assign sr_target = field_q == REG_SR_CODE;
  assign src_word = (state_q == ST_REG) ?
                    (sr_target ? sr_q : reg_rdata_i) : data_q;
  assign new_word = op_zero_q ? (src_word & ~mask_w) : (src_word ^ mask_w);
  assign mem_done = state_q == ST_WRITE && mem_ack_i;
  assign reg_done = state_q == ST_REG;

  always_comb begin
    unique case (kind_q)
      KIND_ABS: dest_addr = {18'h00000, field_q};
      KIND_HIO: dest_addr = HIGH_IO_BASE | {18'h00000, field_q};
      KIND_LIO: dest_addr = LOW_IO_BASE | {18'h00000, field_q};
      default: dest_addr = ea_addr_q;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      dat_q <= 32'h00000000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
        unique case (wb_adr_i)
          OFF_CMD: dat_q <= {16'h0000, field_q, kind_q, space_q,
                             op_zero_q, bit_q};
          OFF_EA_ADDR: dat_q <= {8'h00, ea_addr_q};
          OFF_STATUS: dat_q <= {29'h00000000, old_bit_q, reject_q,
                                state_q != ST_IDLE};
          OFF_SR: dat_q <= {8'h00, sr_q};
          OFF_RESULT: dat_q <= {8'h00, result_q};
          default: dat_q <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_q <= 5'h00;
      op_zero_q <= 1'b0;
      space_q <= 1'b0;
      kind_q <= KIND_EA;
      field_q <= 6'h00;
      reject_q <= 1'b0;
    end else if (cmd_wr && state_q == ST_IDLE) begin
      reject_q <= ~cmd_legal;
      if (cmd_legal) begin
        bit_q <= cmd_bit;
        op_zero_q <= wb_dat_i[CMD_OP_POS];
        space_q <= wb_dat_i[CMD_SPACE_POS];
        kind_q <= bttm_kind_t'(cmd_kind);
        field_q <= cmd_field;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ea_addr_q <= 24'h000000;
    end else if (wb_wr && wb_adr_i == OFF_EA_ADDR && state_q == ST_IDLE) begin
      ea_addr_q <= wb_dat_i[WORD_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= (bttm_kind_t'(cmd_kind) == KIND_REG) ? ST_REG : ST_READ;
          end
        end
        ST_READ: if (mem_ack_i) state_q <= ST_WRITE;
        ST_WRITE: if (mem_ack_i) state_q <= ST_IDLE;
        ST_REG: state_q <= ST_IDLE;
      endcase
    end
  end

  // Lock rises with the read and falls only after the write is acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_lock_q <= 1'b0;
      mem_addr_q <= 24'h000000;
      mem_wdata_q <= 24'h000000;
      data_q <= 24'h000000;
    end else begin
      if (state_q == ST_IDLE && start &&
          bttm_kind_t'(cmd_kind) != KIND_REG) begin
        mem_req_q <= 1'b1;
        mem_lock_q <= 1'b1;
        mem_we_q <= 1'b0;
      end
      if (state_q == ST_READ) begin
        mem_addr_q <= dest_addr;
        if (mem_ack_i) begin
          data_q <= mem_rdata_i;
          mem_we_q <= 1'b1;
          mem_wdata_q <= op_zero_q ? (mem_rdata_i & ~mask_w)
                                   : (mem_rdata_i ^ mask_w);
        end
      end
      if (mem_done) begin
        mem_req_q <= 1'b0;
        mem_we_q <= 1'b0;
        mem_lock_q <= 1'b0;
      end
    end
  end

  // Address is valid from the first request cycle since kind is registered
  assign mem_req_o = mem_req_q;
  assign mem_we_o = mem_we_q;
  assign mem_lock_o = mem_lock_q;
  assign mem_space_o = space_q;
  assign mem_addr_o = (state_q == ST_READ) ? dest_addr : mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;

  // Register destinations never touch the memory bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_we_q <= 1'b0;
      reg_wdata_q <= 24'h000000;
    end else begin
      reg_we_q <= reg_done && !sr_target;
      if (reg_done) begin
        reg_wdata_q <= new_word;
      end
    end
  end

  assign reg_sel_o = field_q;
  assign reg_we_o = reg_we_q;
  assign reg_wdata_o = reg_wdata_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= 24'h000000;
      old_bit_q <= 1'b0;
    end else if (mem_done || reg_done) begin
      result_q <= mem_done ? mem_wdata_q : new_word;
      old_bit_q <= |(src_word & mask_w);
    end
  end

  // Instruction update wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_q <= SR_RESET;
    end else if (reg_done && sr_target) begin
      sr_q <= new_word;
    end else if (mem_done || reg_done) begin
      // Mode byte and V, Z, N, U, E untouched here
      sr_q[SR_CARRY] <= |(src_word & mask_w);
      sr_q[SR_LIMIT] <= sr_q[SR_LIMIT] | std_limit_i;
      sr_q[SR_SCALE] <= sr_q[SR_SCALE] | std_scale_i;
    end else if (wb_wr && wb_adr_i == OFF_SR) begin
      sr_q <= wb_dat_i[WORD_W-1:0];
    end
  end

  sequence s_read_ack;
    state_q == ST_READ && mem_ack_i;
  endsequence
  sequence s_write_ack;
    state_q == ST_WRITE && mem_ack_i;
  endsequence
  property p_lock_held;
    @(posedge clk_i) disable iff (rst_i)
      s_read_ack |=> mem_lock_o && mem_we_o && mem_req_o;
  endproperty
  a_lock_held: assert property (p_lock_held)
    else $error("Lock or write request missing after read");
  property p_invert_word;
    @(posedge clk_i) disable iff (rst_i)
      (s_read_ack and !op_zero_q) ##1 1'b1 |->
        mem_wdata_o == ($past(mem_rdata_i) ^ $past(mask_w));
  endproperty
  a_invert_word: assert property (p_invert_word)
    else $error("Inverted write word wrong");
  property p_zero_word;
    @(posedge clk_i) disable iff (rst_i)
      (s_read_ack and op_zero_q) ##1 1'b1 |->
        mem_wdata_o == ($past(mem_rdata_i) & ~$past(mask_w));
  endproperty
  a_zero_word: assert property (p_zero_word)
    else $error("Cleared write word wrong");
  property p_carry_mem;
    @(posedge clk_i) disable iff (rst_i)
      s_write_ack |=> sr_q[SR_CARRY] == $past(|(data_q & mask_w)) &&
        sr_q[MODE_MSB:MODE_LSB] == $past(sr_q[MODE_MSB:MODE_LSB]);
  endproperty
  a_carry_mem: assert property (p_carry_mem)
    else $error("Carry or mode byte wrong after memory update");
  property p_bad_bit;
    @(posedge clk_i) disable iff (rst_i)
      (cmd_wr && state_q == ST_IDLE && cmd_bit > BIT_MAX) |=>
        reject_q && state_q == ST_IDLE;
  endproperty
  a_bad_bit: assert property (p_bad_bit)
    else $error("Bit number above 23 not rejected");
  property p_acc_reject;
    @(posedge clk_i) disable iff (rst_i)
      (cmd_wr && state_q == ST_IDLE && wb_dat_i[CMD_OP_POS] &&
       cmd_kind == KIND_REG && cmd_field == REG_ACC_A_CODE) |=>
        reject_q ##1 !reg_we_o;
  endproperty
  a_acc_reject: assert property (p_acc_reject)
    else $error("Full accumulator accepted by zero op");
  property p_high_io;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == ST_READ && kind_q == KIND_HIO) |->
        mem_addr_o == {18'h3FFFF, field_q};
  endproperty
  a_high_io: assert property (p_high_io)
    else $error("High I/O address wrong");
  property p_reg_no_bus;
    @(posedge clk_i) disable iff (rst_i)
      reg_done |-> !mem_req_o && !mem_lock_o ##1 !mem_req_o;
  endproperty
  a_reg_no_bus: assert property (p_reg_no_bus)
    else $error("Memory bus used for register destination");
  property p_sr_invert;
    @(posedge clk_i) disable iff (rst_i)
      (reg_done && sr_target && !op_zero_q) |=>
        sr_q == ($past(sr_q) ^ $past(mask_w));
  endproperty
  a_sr_invert: assert property (p_sr_invert)
    else $error("Status register invert changed other bits");
endmodule

//--- tb/bttm_mem_model.sv
// Behavioural X/Y data memory on the core bus with wait states
`timescale 1ns/10ps
module bttm_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic mem_lock_i,
  input wire logic mem_space_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [23:0] mem_wdata_i,
  input wire logic [3:0] wait_i,
  output logic mem_ack_o,
  output logic [23:0] mem_rdata_o
);
  logic [23:0] xm [bit [23:0]];
  logic [23:0] ym [bit [23:0]];
  logic [3:0] cnt_q;
  logic [23:0] radr_q;
  int n_rd;
  int n_wr;
  int n_bad;
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    // Data toggles when not answering so a late sample cannot match
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_i) begin
      cnt_q <= 4'h0;
      mem_rdata_o <= 24'h5A5A5A;
    end else if (mem_req_i && !mem_ack_o) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == wait_i) begin
        cnt_q <= 4'h0;
        mem_ack_o <= 1'b1;
        if (!mem_lock_i) n_bad++;
        if (mem_we_i) begin
          n_wr++;
          if (mem_addr_i != radr_q) n_bad++;
          if (mem_space_i) ym[mem_addr_i] = mem_wdata_i;
          else xm[mem_addr_i] = mem_wdata_i;
        end else begin
          n_rd++;
          radr_q <= mem_addr_i;
          mem_rdata_o <= mem_space_i ? ym[mem_addr_i] : xm[mem_addr_i];
        end
      end
    end
  end
endmodule

//--- tb/bit_test_modify_unit_tb_top.sv
// Self-checking bench for the bit test-and-modify unit
`timescale 1ns/10ps
module bit_test_modify_unit_tb_top;
  import bttm_pkg::*;
  localparam logic [5:0] SR_CODE = 6'h39;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic lim = 1'b0;
  logic scl = 1'b0;
  logic [3:0] wt = 4'h0;
  logic [31:0] dat_o;
  logic ack, req, mwe, lock, spc, mack, rwe;
  logic [23:0] maddr, mwd, mrd, rrd, rwd;
  logic [5:0] rsel;
  logic [23:0] rf [64];
  logic [23:0] sr_exp = 24'h0;
  int error_cnt = 0;
  int n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  assign rrd = rf[rsel];
  always @(posedge clk_i) if (rwe) rf[rsel] <= rwd;
  bttm_unit #(.REG_SR_CODE(SR_CODE)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .mem_req_o(req), .mem_we_o(mwe),
    .mem_lock_o(lock), .mem_space_o(spc), .mem_addr_o(maddr),
    .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd),
    .reg_sel_o(rsel), .reg_rdata_i(rrd), .reg_we_o(rwe),
    .reg_wdata_o(rwd), .std_limit_i(lim), .std_scale_i(scl));
  bttm_mem_model mem (
    .clk_i(clk_i), .rst_i(rst_i), .mem_req_i(req), .mem_we_i(mwe),
    .mem_lock_i(lock), .mem_space_i(spc), .mem_addr_i(maddr),
    .mem_wdata_i(mwd), .wait_i(wt), .mem_ack_o(mack), .mem_rdata_o(mrd));
  task end_of_test;
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      end_of_test;
    end
    q = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask
  // Issue a command, then poll busy under a bounded count
  task go(input logic [31:0] c, output logic [31:0] q);
    int n;
    n = 0;
    wr(OFF_CMD, c);
    do begin
      wb(1'b0, OFF_STATUS, 32'h0, q);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      end_of_test;
    end
  endtask
  function automatic logic [31:0] cmd(input logic [4:0] b,
    input logic op, sp, input logic [2:0] k, input logic [5:0] f);
    return {16'h0, f, k, sp, op, b};
  endfunction
  task mem_case(input logic op, sp, input logic [2:0] k,
    input logic [5:0] f, input logic [4:0] b, input logic [23:0] a, v,
    input logic [3:0] w);
    logic [23:0] e;
    logic [31:0] q;
    int r0;
    int w0;
    wt <= w;
    e = op ? v & ~(24'h1 << b) : v ^ (24'h1 << b);
    if (sp) mem.ym[a] = v;
    else mem.xm[a] = v;
    r0 = mem.n_rd;
    w0 = mem.n_wr;
    wr(OFF_EA_ADDR, {8'h0, a});
    go(cmd(b, op, sp, k, f), q);
    sr_exp = {sr_exp[23:8], sr_exp[7] | scl, sr_exp[6] | lim,
              sr_exp[5:1], v[b]};
    q = {8'h0, sp ? mem.ym[a] : mem.xm[a]};
    check("mem word", q, {8'h0, e});
    check("reads", mem.n_rd - r0, 1);
    check("writes", mem.n_wr - w0, 1);
    rd_chk("ea", OFF_EA_ADDR, {8'h0, a});
    rd_chk("cmd", OFF_CMD, cmd(b, op, sp, k, f));
    wb(1'b0, OFF_STATUS, 32'h0, q);
    check("old bit", q[STAT_OLD_BIT], v[b]);
    rd_chk("result", OFF_RESULT, {8'h0, e});
    rd_chk("flags", OFF_SR, {8'h0, sr_exp});
  endtask
  task reg_case(input logic op, input logic [5:0] c, input logic [4:0] b,
    input logic [23:0] v, input logic rej);
    logic [23:0] m;
    logic [31:0] q;
    int r0;
    m = 24'h1 << b;
    rf[c] = v;
    r0 = mem.n_rd;
    go(cmd(b, op, 1'b0, KIND_REG, c), q);
    check("reject", q[STAT_REJECT], rej);
    if (c == SR_CODE) begin
      if (!rej) sr_exp = op ? sr_exp & ~m : sr_exp ^ m;
    end else begin
      check("reg", rf[c], rej ? v : (op ? v & ~m : v ^ m));
      if (!rej) sr_exp = {sr_exp[23:8], sr_exp[7] | scl,
                          sr_exp[6] | lim, sr_exp[5:1], v[b]};
    end
    rd_chk("sr", OFF_SR, {8'h0, sr_exp});
    check("no bus", mem.n_rd - r0, 0);
  endtask
  initial begin
    #500000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    logic [31:0] q;
    for (int i = 0; i < 64; i++) rf[i] = 24'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("status rst", OFF_STATUS, 32'h0);
    rd_chk("sr rst", OFF_SR, {8'h0, SR_RESET});
    rd_chk("unmapped", 8'h20, 32'h0);
    mem_case(0, 0, KIND_EA, 6'h00, 5'h17, 24'h001234, 24'h7FFFFF, 4'h0);
    mem_case(1, 1, KIND_ABS, 6'h3F, 5'h00, 24'h00003F, 24'h000001, 4'h3);
    mem_case(0, 0, KIND_HIO, 6'h3F, 5'h05, 24'hFFFFFF, 24'hFFFFFF, 4'h1);
    lim <= 1'b1;
    mem_case(1, 1, KIND_LIO, 6'h00, 5'h0C, 24'hFFFF80, 24'h00F000, 4'h2);
    scl <= 1'b1;
    mem_case(1, 0, KIND_LIO, 6'h3F, 5'h16, 24'hFFFFBF, 24'h400000, 4'h0);
    mem_case(0, 1, KIND_HIO, 6'h00, 5'h09, 24'hFFFFC0, 24'h000000, 4'h4);
    reg_case(0, 6'h0E, 5'h04, 24'h000010, 0);
    reg_case(1, 6'h0E, 5'h04, 24'h000010, 1);
    reg_case(1, 6'h0F, 5'h01, 24'h000002, 1);
    reg_case(1, 6'h10, 5'h07, 24'h0000FF, 0);
    reg_case(1, 6'h10, 5'h18, 24'h000000, 1);
    wr(OFF_SR, 32'h00A55A);
    sr_exp = 24'h00A55A;
    reg_case(0, SR_CODE, 5'h02, 24'h0, 0);
    reg_case(1, SR_CODE, 5'h06, 24'h0, 0);
    reg_case(0, SR_CODE, 5'h0D, 24'h0, 0);
    reg_case(1, SR_CODE, 5'h08, 24'h0, 0);
    reg_case(0, SR_CODE, 5'h00, 24'h0, 0);
    reg_case(1, 6'h10, 5'h03, 24'h000008, 0);
    go(cmd(5'h00, 1'b0, 1'b0, 3'h5, 6'h00), q);
    check("bad kind", q[STAT_REJECT], 1'b1);
    check("lock held", mem.n_bad, 0);
    end_of_test;
  end
endmodule
